// [rtl/baud_match_pkg.sv]
// shared constants and types for the automatic baud matcher
package baud_match_pkg;

  // ==========================================================
  // widths
  localparam int COUNT_W = 24;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam int DIV_W = 16;

  // ==========================================================
  // clock and line rates
  localparam longint CLK_HZ = 250000000;
  localparam longint INTERNAL_CLOCK_HZ = 15625000;
  localparam int NOMINAL_BAUD = 4800;
  localparam int MAX_BAUD = 38400;
  localparam int DIV_SHIFT = 3;

  // ==========================================================
  // register offsets (own choice; nothing printed)
  localparam logic [3:0] OFF_P0_LOW = 4'h0;
  localparam logic [3:0] OFF_P0_MID = 4'h1;
  localparam logic [3:0] OFF_P0_HIGH = 4'h2;
  localparam logic [3:0] OFF_P1_LOW = 4'h4;
  localparam logic [3:0] OFF_P1_MID = 4'h5;
  localparam logic [3:0] OFF_P1_HIGH = 4'h6;
  localparam logic [3:0] OFF_CONTROL = 4'h8;
  localparam logic [3:0] OFF_STATUS = 4'h9;
  localparam logic [3:0] OFF_MATCHES = 4'ha;

  // ==========================================================
  // reset values: divisor 405 = 15625000/(8*4800)-1
  localparam logic [7:0] RESET_LOW = 8'h95;
  localparam logic [7:0] RESET_MID = 8'h01;
  localparam logic [7:0] RESET_HIGH = 8'h00;
  localparam logic [7:0] RESET_CONTROL = 8'h01;

  // control and status field positions
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int STAT_BITS_LSB = 0;
  localparam int STAT_ERROR_BIT = 4;
  localparam int STAT_LEVEL_BIT = 5;

  // ==========================================================
  // acceptance windows in internal clock cycles
  localparam logic [23:0] WIN1_LO = 24'd2950;
  localparam logic [23:0] WIN1_HI = 24'd3260;
  localparam logic [23:0] WIN2_LO = 24'd5900;
  localparam logic [23:0] WIN2_HI = 24'd7240;
  localparam logic [23:0] WIN3_LO = 24'd8850;
  localparam logic [23:0] WIN3_HI = 24'd10860;
  localparam logic [23:0] WIN4_LO = 24'd11801;
  localparam logic [23:0] WIN4_HI = 24'd14481;

  typedef enum logic [1:0] {
    WAIT_FALL,
    WAIT_RISE,
    CLASSIFY
  } capture_state_type;

  typedef struct packed {
    logic [7:0] high;
    logic [7:0] middle;
    logic [7:0] low;
  } divisor_type;

endpackage : baud_match_pkg

// [rtl/pulse_classifier.sv]
// classifies a low pulse width and derives the divisor from it
`timescale 1ns/100ps
module pulse_classifier
  import baud_match_pkg::*;
(
  input wire logic [baud_match_pkg::COUNT_W-1:0] width,
  output logic [2:0] bit_count,
  output logic [baud_match_pkg::DIV_W-1:0] divisor
);

  // ==========================================================
  // window match and scaled divisor
  logic [COUNT_W+11:0] prod3;

  always_comb begin
    prod3 = {12'h000, width} * 36'd2730;
    bit_count = 3'd0;
    divisor = '0;
    if (width >= WIN1_LO && width <= WIN1_HI) begin
      bit_count = 3'd1;
      divisor = DIV_W'((width >> DIV_SHIFT) - 24'd1);
    end else if (width >= WIN2_LO && width <= WIN2_HI) begin
      bit_count = 3'd2;
      divisor = DIV_W'((width >> 4) - 24'd1);
    end else if (width >= WIN3_LO && width <= WIN3_HI) begin
      bit_count = 3'd3;
      divisor = DIV_W'((prod3 >> 16) - 36'd1);
    end else if (width >= WIN4_LO && width <= WIN4_HI) begin
      bit_count = 3'd4;
      divisor = DIV_W'((width >> 5) - 24'd1);
    end
    // anything else, five bits and longer included, stays 0
  end

endmodule : pulse_classifier

// [rtl/auto_baud_matcher.sv]
// automatic baud matcher: pulse capture, classification, divide registers
//
// The address-and-strobe port and the register offsets are this design's own decisions.
`timescale 1ns/100ps
module auto_baud_matcher
  import baud_match_pkg::*;
#(
  parameter longint TICK_HZ = baud_match_pkg::INTERNAL_CLOCK_HZ
) (
  input wire logic MCLK,
  input wire logic RESET_N,
  input wire logic SERIAL_RECEIVE_INPUT,
  input wire logic [baud_match_pkg::ADDR_W-1:0] ADDR,
  input wire logic [baud_match_pkg::DATA_W-1:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [baud_match_pkg::DATA_W-1:0] RDATA,
  output baud_match_pkg::divisor_type FIRST_PORT_DIVISOR,
  output baud_match_pkg::divisor_type SECOND_PORT_DIVISOR,
  output logic MATCH_PULSE
);
  import baud_match_pkg::*;

  // internal tick: internal clock ticks per fast clock, scaled x256
  localparam longint TICK_STEP_L = (TICK_HZ * 256 + CLK_HZ / 2) / CLK_HZ;
  localparam logic [15:0] TICK_STEP = 16'(TICK_STEP_L);

  // ==========================================================
  // line synchroniser
  logic rx_meta_q;
  logic rx_sync_q;
  logic rx_prev_q;

  // two flops before anything reads the pin
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rx_meta_q <= 1'b1;
      rx_sync_q <= 1'b1;
      rx_prev_q <= 1'b1;
    end else begin
      rx_meta_q <= SERIAL_RECEIVE_INPUT;
      rx_sync_q <= rx_meta_q;
      rx_prev_q <= rx_sync_q; // idle high
    end
  end

  logic fall_edge;
  logic rise_edge;
  assign fall_edge = rx_prev_q & ~rx_sync_q;
  assign rise_edge = ~rx_prev_q & rx_sync_q;

  // ==========================================================
  // free-running 24-bit counter at the internal clock rate
  logic [15:0] phase_q;
  logic [16:0] phase_sum;
  logic [COUNT_W-1:0] count_q;
  assign phase_sum = {1'b0, phase_q} + {1'b0, TICK_STEP} * 17'd256;

  // fractional accumulator producing internal clock ticks
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      phase_q <= 16'h0000;
      count_q <= '0;
    end else begin
      phase_q <= phase_sum[15:0];
      if (phase_sum[16]) begin
        count_q <= count_q + 24'd1;
      end
    end
  end

  // ==========================================================
  // control registers
  logic [7:0] control_q;
  logic enable;
  assign enable = control_q[CTRL_ENABLE_BIT];

  // ==========================================================
  // capture sequencer
  capture_state_type state_q;
  logic [COUNT_W-1:0] start_q;
  logic [COUNT_W-1:0] width_q;

  // latch on fall, subtract on rise, then classify
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      state_q <= WAIT_FALL;
      start_q <= '0;
      width_q <= '0;
    end else begin
      case (state_q)
        WAIT_FALL: begin
          if (fall_edge && enable) begin
            start_q <= count_q;
            state_q <= WAIT_RISE;
          end
        end
        WAIT_RISE: begin
          if (rise_edge) begin
            width_q <= count_q - start_q;
            state_q <= CLASSIFY;
          end
        end
        CLASSIFY: begin
          state_q <= WAIT_FALL;
        end
        default: begin
          state_q <= WAIT_FALL;
        end
      endcase
    end
  end

  // ==========================================================
  // classification
  logic [2:0] bit_count;
  logic [DIV_W-1:0] new_divisor;
  logic accept;

  pulse_classifier u_classifier (
    .width(width_q),
    .bit_count(bit_count),
    .divisor(new_divisor)
  );

  assign accept = (state_q == CLASSIFY) && (bit_count != 3'd0);

  // ==========================================================
  // divide registers of both ports
  divisor_type port0_q;
  divisor_type port1_q;
  logic [7:0] matches_q;
  logic [2:0] last_bits_q;
  logic error_q;

  // bus write decode used for both ports
  function automatic logic hit(input logic [3:0] a, input logic [3:0] off);
    hit = (a == off);
  endfunction : hit

  // port 0 divisor: reset static value, accepted pulse or bus write
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      port0_q <= '{high: RESET_HIGH, middle: RESET_MID,
                   low: RESET_LOW};
    end else if (accept) begin
      port0_q.low <= new_divisor[7:0];
      port0_q.middle <= new_divisor[15:8];
      port0_q.high <= 8'h00;
    end else if (WR) begin
      if (hit(ADDR, OFF_P0_LOW)) port0_q.low <= WDATA;
      if (hit(ADDR, OFF_P0_MID)) port0_q.middle <= WDATA;
      if (hit(ADDR, OFF_P0_HIGH)) port0_q.high <= WDATA;
    end
  end

  // port 1 divisor: same update as port 0
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      port1_q <= '{high: RESET_HIGH, middle: RESET_MID, low: RESET_LOW};
    end else if (accept) begin
      port1_q.low <= new_divisor[7:0];
      port1_q.middle <= new_divisor[15:8];
      port1_q.high <= 8'h00;
    end else if (WR) begin
      if (hit(ADDR, OFF_P1_LOW)) port1_q.low <= WDATA;
      if (hit(ADDR, OFF_P1_MID)) port1_q.middle <= WDATA;
      if (hit(ADDR, OFF_P1_HIGH)) port1_q.high <= WDATA;
    end
  end

  // control register
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      control_q <= RESET_CONTROL;
    end else if (WR && hit(ADDR, OFF_CONTROL)) begin
      control_q <= WDATA;
    end
  end

  // status: last class, error flag, match counter
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      last_bits_q <= 3'd0;
      error_q <= 1'b0;
      matches_q <= 8'h00;
      MATCH_PULSE <= 1'b0;
    end else begin
      MATCH_PULSE <= accept;
      if (state_q == CLASSIFY) begin
        last_bits_q <= bit_count;
      end
      // set wins over software clear
      if (state_q == CLASSIFY && !accept) begin
        error_q <= 1'b1;
      end else if (WR && hit(ADDR, OFF_STATUS)) begin
        error_q <= 1'b0;
      end
      if (accept) begin
        matches_q <= matches_q + 8'h01;
      end
    end
  end

  // ==========================================================
  // read port: data in the cycle after the strobe
  logic [7:0] rd_mux;
  always_comb begin
    case (ADDR)
      OFF_P0_LOW: rd_mux = port0_q.low;
      OFF_P0_MID: rd_mux = port0_q.middle;
      OFF_P0_HIGH: rd_mux = port0_q.high;
      OFF_P1_LOW: rd_mux = port1_q.low;
      OFF_P1_MID: rd_mux = port1_q.middle;
      OFF_P1_HIGH: rd_mux = port1_q.high;
      OFF_CONTROL: rd_mux = control_q;
      OFF_STATUS: rd_mux = {2'b00, rx_sync_q, error_q, 1'b0, last_bits_q};
      OFF_MATCHES: rd_mux = matches_q;
      default: rd_mux = 8'h00;
    endcase
  end

  // read data register
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      RDATA <= 8'h00;
    end else if (RD) begin
      RDATA <= rd_mux;
    end else begin
      RDATA <= 8'h00;
    end
  end

  // divisor outputs registered
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      FIRST_PORT_DIVISOR <= '{high: RESET_HIGH, middle: RESET_MID,
                              low: RESET_LOW};
      SECOND_PORT_DIVISOR <= '{high: RESET_HIGH, middle: RESET_MID,
                               low: RESET_LOW};
    end else begin
      FIRST_PORT_DIVISOR <= port0_q;
      SECOND_PORT_DIVISOR <= port1_q;
    end
  end

endmodule : auto_baud_matcher

// [bench/abm_checker.sv]
// port assertions for the automatic baud matcher
`timescale 1ns/100ps
module abm_checker
  import baud_match_pkg::*;
(
  input wire logic MCLK,
  input wire logic RESET_N,
  input wire logic SERIAL_RECEIVE_INPUT,
  input wire logic [baud_match_pkg::ADDR_W-1:0] ADDR,
  input wire logic [baud_match_pkg::DATA_W-1:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  input wire logic [baud_match_pkg::DATA_W-1:0] RDATA,
  input wire baud_match_pkg::divisor_type FIRST_PORT_DIVISOR,
  input wire baud_match_pkg::divisor_type SECOND_PORT_DIVISOR,
  input wire logic MATCH_PULSE
);
  // ==========================================================
  // properties
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RESET_N);
  logic [15:0] div_d;
  // first port divisor without the high part
  assign div_d = {FIRST_PORT_DIVISOR.middle, FIRST_PORT_DIVISOR.low};
  // divisor outputs settle one cycle after the match pulse
  property p_high_zero;
    MATCH_PULSE |=> FIRST_PORT_DIVISOR.high == 8'h00 &&
      SECOND_PORT_DIVISOR.high == 8'h00;
  endproperty
  a_high_zero: assert property (p_high_zero)
    else $error("high not 0");
  property p_both;
    MATCH_PULSE |=> FIRST_PORT_DIVISOR == SECOND_PORT_DIVISOR;
  endproperty
  a_both: assert property (p_both)
    else $error("ports differ");
  property p_range;
    MATCH_PULSE |=> div_d >= 16'd367 && div_d <= 16'd451;
  endproperty
  a_range: assert property (p_range)
    else $error("divisor range");
  property p_single;
    MATCH_PULSE |=> !MATCH_PULSE;
  endproperty
  a_single: assert property (p_single)
    else $error("long match");
  // a move is seen one sample after a match pulse or two samples after a bus write
  property p_hold;
    $changed(FIRST_PORT_DIVISOR) |-> $past(MATCH_PULSE) || $past(WR, 2);
  endproperty
  a_hold: assert property (p_hold)
    else $error("divisor moved");
  property p_after_rise;
    !SERIAL_RECEIVE_INPUT [*8] |-> !MATCH_PULSE;
  endproperty
  a_after_rise: assert property (p_after_rise)
    else $error("match low");
  property p_rise_before;
    MATCH_PULSE |-> $past(SERIAL_RECEIVE_INPUT);
  endproperty
  a_rise_before: assert property (p_rise_before)
    else $error("no rise");
  property p_read_idle;
    !RD |=> RDATA == 8'h00;
  endproperty
  a_read_idle: assert property (p_read_idle)
    else $error("rdata idle");
  property p_high_read;
    RD && ADDR == OFF_P1_HIGH |=> RDATA == 8'h00;
  endproperty
  a_high_read: assert property (p_high_read)
    else $error("high read");
  c_match: cover property (MATCH_PULSE);
  c_read: cover property (RD ##1 RDATA != 8'h00);
  c_write: cover property (WR && ADDR == OFF_P0_LOW);
endmodule : abm_checker

bind auto_baud_matcher abm_checker chk (.MCLK, .RESET_N,
  .SERIAL_RECEIVE_INPUT, .ADDR, .WDATA, .WR, .RD, .RDATA,
  .FIRST_PORT_DIVISOR, .SECOND_PORT_DIVISOR, .MATCH_PULSE);

// [bench/serial_sender.sv]
// far-side serial transmitter model driving the receive line
`timescale 1ns/100ps
module serial_sender (
  input wire logic clk,
  output logic line
);
  // ==========================================================
  // line drive
  initial line = 1'b1;
  // one low run of the given length in clock cycles
  task automatic send_low(input int cycles);
    line <= 1'b0;
    repeat (cycles) @(posedge clk);
    line <= 1'b1;
  endtask : send_low
  // start, eight data bits lsb first, two stops
  task automatic send_byte(input logic [7:0] b, input int bit_cycles);
    logic [10:0] bits;
    bits = {2'b11, b, 1'b0};
    for (int i = 0; i < 11; i++) begin
      line <= bits[i];
      repeat (bit_cycles) @(posedge clk);
    end
  endtask : send_byte
endmodule : serial_sender

// [bench/auto_baud_matcher_test.sv]
// self-checking bench for the automatic baud matcher
`timescale 1ns/100ps
module auto_baud_matcher_test;
  import baud_match_pkg::*;
  // ==========================================================
  // signals
  logic mclk = 1'b0;
  logic reset_n = 1'b1;
  logic rx;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] rdata;
  logic [7:0] v;
  divisor_type div0;
  divisor_type div1;
  logic match;
  int num_errors = 0;
  int n_checks = 0;
  int n_match = 0;
  int wid[3] = '{6520, 9780, 12016};
  // clock and match counter
  always #2 mclk = ~mclk;
  always @(posedge mclk) if (match === 1'b1) n_match <= n_match + 1;
  // ==========================================================
  // design and far side
  auto_baud_matcher #(.TICK_HZ(250000000)) dut (.MCLK(mclk),
    .RESET_N(reset_n), .SERIAL_RECEIVE_INPUT(rx), .ADDR(addr),
    .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
    .FIRST_PORT_DIVISOR(div0), .SECOND_PORT_DIVISOR(div1),
    .MATCH_PULSE(match));
  serial_sender far (.clk(mclk), .line(rx));
  // ==========================================================
  // tasks
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    @(posedge mclk);
    d = rdata;
  endtask : rd_reg
  function automatic logic [15:0] exp_div(input int w, input int n);
    case (n)
      1: return 16'((w >> 3) - 1);
      2: return 16'((w >> 4) - 1);
      3: return 16'(((w * 2730) >> 16) - 1);
      default: return 16'((w >> 5) - 1);
    endcase
  endfunction : exp_div
  task automatic chk_div(input logic [15:0] e);
    chk({div0.middle, div0.low}, e);
    chk({div1.middle, div1.low}, e);
    chk({div0.high, div1.high}, 16'h0000);
  endtask : chk_div
  // one low pulse; n is the bit count, 0 when it must be refused
  task automatic pulse(input int w, input int n);
    int m;
    m = n_match;
    far.send_low(w);
    for (int i = 0; i < 40 && n_match == m; i++) @(posedge mclk);
    chk(16'(n_match - m), (n > 0) ? 16'd1 : 16'd0);
    if (n > 0) chk_div(exp_div(w, n));
  endtask : pulse
  task automatic close_out;
    if (num_errors == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : close_out
  // ==========================================================
  // hang guard
  initial begin
    repeat (99000) @(posedge mclk);
    num_errors++;
    close_out;
  end
  // main sequence
  initial begin
    // reset edge after every process waits on it
    reset_n <= 1'b0;
    repeat (12) @(posedge mclk);
    reset_n <= 1'b1;
    @(posedge mclk);
    chk_div(16'd405);
    rd_reg(OFF_P0_LOW, v);
    chk(16'(v), 16'h0095);
    rd_reg(OFF_P0_MID, v);
    chk(16'(v), 16'h0001);
    rd_reg(OFF_P1_HIGH, v);
    chk(16'(v), 16'h0000);
    rd_reg(4'h3, v);
    chk(16'(v), 16'h0000);
    wr_reg(OFF_P0_LOW, 8'h5a);
    rd_reg(OFF_P0_LOW, v);
    chk(16'(v), 16'h005a);
    rd_reg(OFF_P1_LOW, v);
    chk(16'(v), 16'h0095);
    far.send_byte(8'hfd, 2964);
    repeat (40) @(posedge mclk);
    chk(16'(n_match), 16'd2);
    chk_div(exp_div(2964, 1));
    for (int i = 0; i < 3; i++) pulse(wid[i], i + 2);
    pulse(2000, 0);
    pulse(4500, 0);
    pulse(15000, 0);
    chk_div(exp_div(12016, 4));
    rd_reg(OFF_STATUS, v);
    chk(16'(v[4]), 16'h0001);
    chk(16'(v[2:0]), 16'h0000);
    // error flag cleared by a status write, line level high
    wr_reg(OFF_STATUS, 8'h00);
    rd_reg(OFF_STATUS, v);
    chk(16'(v), 16'h0020);
    wr_reg(OFF_CONTROL, 8'h00);
    pulse(3100, 0);
    wr_reg(OFF_CONTROL, 8'h01);
    pulse(3100, 1);
    // two from the byte, three longer pulses, one final
    rd_reg(OFF_MATCHES, v);
    chk(16'(v), 16'h0006);
    close_out;
  end
endmodule : auto_baud_matcher_test
